// [bench/cxse_cam.sv]
// camera model: image headers and pixel beats on valid/ready
// assumes send_frame is started at a clock edge, one frame at a time
`timescale 1ns/1ps
module cxse_cam import cxse_pkg::*; #(
    parameter logic [SID_W-1:0] SID = 8'h03
) (
    input wire logic clk,
    input wire logic in_ready,
    output logic hdr_valid,
    output cxse_hdr_s hdr,
    output logic in_valid,
    output cxse_pix_s in_pix,
    output logic hung
);
    logic [63:0] junk = 64'h5A5AC3C30F0F9696;
    cxse_hdr_s hcur;
    cxse_pix_s cur;
    logic [PIX_W-1:0] seq_q = 16'h0100;
    initial begin
        hdr_valid = 1'b0;
        in_valid = 1'b0;
        hung = 1'b0;
    end
    // released lines toggle every cycle
    always @(posedge clk) begin
        junk <= ~junk;
    end
    assign hdr = hdr_valid ? hcur : cxse_hdr_s'(junk[$bits(cxse_hdr_s)-1:0]);
    assign in_pix = in_valid ? cur : cxse_pix_s'(junk[$bits(cxse_pix_s)-1:0]);
    // header pulse, then beats held until taken
    task automatic send_frame(input logic [TAG_W-1:0] tag, input logic [DIM_W-1:0] w,
            input logic [DIM_W-1:0] h, input int n, input logic mk);
        int i;
        int t;
        hcur <= '{tag: tag, sid: SID, width: w, height: h, marker_err: mk, uncorr_err: mk};
        hdr_valid <= 1'b1;
        @(posedge clk);
        hdr_valid <= 1'b0;
        for (i = 0; i < n; i++) begin
            cur <= '{data: seq_q, line_end: 1'b0, frame_end: i == n - 1};
            seq_q = seq_q + 16'h0001;
            in_valid <= 1'b1;
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (!in_ready && t < 2000);
            if (!in_ready) begin
                hung = 1'b1;
            end
        end
        in_valid <= 1'b0;
    endtask : send_frame
endmodule : cxse_cam

// [bench/cxse_stream_guard_bench.sv]
// bench: camera model feeds the guard, queues hold expected pixels and events
// assumes cxse_cam and a 40 MHz clock
`timescale 1ns/1ps
module cxse_stream_guard_bench import cxse_pkg::*; ();
    localparam logic [SID_W-1:0] SID = 8'h03;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic acq_run = 1'b1;
    logic line_mode = 1'b0;
    logic gen_frame_first = 1'b0;
    logic crc_err = 1'b0;
    logic out_ready = 1'b0;
    logic ev_ready = 1'b0;
    logic hdr_valid, in_valid, in_ready, out_valid, ev_valid, hung;
    logic frame_begin_event, size_mismatch, loss_pending;
    cxse_hdr_s hdr;
    cxse_pix_s in_pix, out_pix;
    cxse_evt_s ev_rec;
    cxse_pix_s exp_pix[$];
    cxse_evt_s exp_ev[$];
    logic [31:0] rnd = 32'hF36DEA7B;
    logic stall = 1'b0;
    logic ign = 1'b1;
    int n_errors = 0;
    int checks = 0;
    int n_begin = 0;
    int exp_begin = 0;

    always #12.5 clk = ~clk;

    cxse_stream_guard DUT (.clk(clk), .rst(rst), .acq_run(acq_run), .line_mode(line_mode),
        .gen_frame_first(gen_frame_first), .hdr_valid(hdr_valid), .hdr(hdr),
        .crc_err(crc_err), .in_valid(in_valid), .in_pix(in_pix), .in_ready(in_ready),
        .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready),
        .ev_valid(ev_valid), .ev_rec(ev_rec), .ev_ready(ev_ready),
        .frame_begin_event(frame_begin_event), .size_mismatch(size_mismatch),
        .loss_pending(loss_pending));

    cxse_cam #(.SID(SID)) cam (.clk(clk), .in_ready(in_ready), .hdr_valid(hdr_valid),
        .hdr(hdr), .in_valid(in_valid), .in_pix(in_pix), .hung(hung));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic cmp_val(input string nm, input logic [63:0] e, input logic [63:0] s);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, e, s);
        end
    endtask : cmp_val

    task automatic cmp_pix(input cxse_pix_s e, input cxse_pix_s s);
        cmp_val("pixel", 64'(e), 64'(s));
    endtask : cmp_pix

    task automatic cmp_ev(input cxse_evt_s e, input cxse_evt_s s);
        cmp_val("event", e, s);
    endtask : cmp_ev

    // random sinks, output monitors
    always @(posedge clk) begin : mon
        cxse_pix_s ep;
        cxse_evt_s ee;
        ep = '1;
        ee = '1;
        rnd = xs(rnd);
        out_ready <= rnd[0] | rnd[1];
        ev_ready <= !stall && rnd[2];
        if (!rst && out_valid && out_ready) begin
            if (exp_pix.size() > 0) ep = exp_pix.pop_front();
            cmp_pix(ep, out_pix);
        end
        if (!rst && ev_valid && ev_ready && !ign) begin
            if (exp_ev.size() > 0) ee = exp_ev.pop_front();
            cmp_ev(ee, ev_rec);
        end
        if (!rst && frame_begin_event) n_begin++;
    end

    task automatic expev(input logic [15:0] tag, input logic [15:0] w2, input logic [15:0] w3);
        exp_ev.push_back('{w3: w3, w2: w2, w1: {SID, 8'h00}, w0: tag});
    endtask : expev

    task automatic drain(input bit pix);
        int k;
        for (k = 0; k < 3000 && (pix ? exp_pix.size() : exp_ev.size()) > 0; k++) begin
            @(posedge clk);
        end
        if ((pix ? exp_pix.size() : exp_ev.size()) > 0 || hung) begin
            $display("mismatch wait expected empty seen busy");
            n_errors++;
            finish_test();
        end
        repeat (3) @(posedge clk);
    endtask : drain

    // header size w by h, n beats sent; crc pulse early in the frame
    task automatic frame(input logic [15:0] tag, input int w, input int h, input int n,
            input logic mk, input logic crc);
        int k;
        cxse_pix_s p;
        for (k = 0; k < w * h; k++) begin
            p.data = k < n ? 16'(cam.seq_q + k) : FILL_PIX;
            p.line_end = k % w == w - 1;
            p.frame_end = k == w * h - 1;
            exp_pix.push_back(p);
        end
        fork
            cam.send_frame(tag, DIM_W'(w), DIM_W'(h), n, mk);
            if (crc) begin
                repeat (2) @(posedge clk);
                crc_err <= 1'b1;
                @(posedge clk);
                crc_err <= 1'b0;
            end
        join
        drain(1'b1);
    endtask : frame

    initial begin
        int i;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        exp_begin = 1;
        frame(16'h0010, 2, 2, 4, 1'b0, 1'b0);
        repeat (40) @(posedge clk);
        ign = 1'b0;
        exp_begin++;
        frame(16'h0011, 2, 2, 4, 1'b0, 1'b0);
        cmp_val("size_flag", 0, size_mismatch);
        expev(16'h0012, 16'h0008, 16'h0000);
        exp_begin++;
        frame(16'h0012, 3, 2, 9, 1'b0, 1'b0);
        cmp_val("size_flag", 1, size_mismatch);
        expev(16'h0013, 16'h0008, 16'h0000);
        exp_begin++;
        frame(16'h0013, 2, 3, 3, 1'b0, 1'b0);
        expev(16'h0014, 16'h0007, 16'h0000);
        exp_begin++;
        frame(16'h0014, 2, 2, 4, 1'b1, 1'b1);
        expev(16'h0015, 16'h0000, 16'h0001);
        exp_begin++;
        frame(16'h0018, 2, 2, 4, 1'b0, 1'b0);
        acq_run <= 1'b0;
        frame(16'h0019, 2, 2, 4, 1'b0, 1'b0);
        acq_run <= 1'b1;
        line_mode <= 1'b1;
        gen_frame_first <= 1'b1;
        exp_begin += 3;
        frame(16'h001A, 2, 3, 6, 1'b0, 1'b0);
        line_mode <= 1'b0;
        gen_frame_first <= 1'b0;
        cmp_val("begins", exp_begin, n_begin);
        drain(1'b0);
        stall = 1'b1;
        for (i = 0; i < 11; i++) begin
            if (i < 9) expev(16'(16'h001B + 2 * i), 16'h0000, 16'h0001);
            exp_begin++;
            frame(16'(16'h001C + 2 * i), 1, 1, 1, 1'b0, i == 10);
        end
        cmp_val("loss_pending", 1, loss_pending);
        stall = 1'b0;
        drain(1'b0);
        expev(16'h0031, 16'h0000, 16'h0017);
        exp_begin++;
        frame(16'h0032, 1, 1, 1, 1'b0, 1'b0);
        expev(16'h0034, 16'h0000, 16'h0001);
        expev(16'h0033, 16'h0008, 16'h0000);
        exp_begin++;
        fork
            frame(16'h0033, 2, 3, 1, 1'b0, 1'b0);
            begin
                repeat (3) @(posedge clk);
                cam.send_frame(16'h0034, DIM_W'(1), DIM_W'(1), 1, 1'b0);
            end
        join
        drain(1'b0);
        cmp_val("loss_pending", 0, loss_pending);
        cmp_val("begins", exp_begin, n_begin);
        finish_test();
    end
endmodule : cxse_stream_guard_bench

// [logic/cxse_fifo.sv]
// synchronous valid/ready fifo, width and depth as parameters
// assumes depth is a power of two; one clock, asynchronous reset
`timescale 1ns/1ps
module cxse_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } cxse_fifo_s;
    cxse_fifo_s q, d;
    logic [W-1:0] mem [DEPTH];
    logic wr_en;
    logic rd_en;

    assign in_ready = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = mem[q.rd];
    assign wr_en = in_valid && in_ready;
    assign rd_en = out_valid && out_ready;

    always_comb begin
        d = q;
        if (wr_en) d.wr = q.wr + 1'b1;
        if (rd_en) d.rd = q.rd + 1'b1;
        if (wr_en && !rd_en) d.cnt = q.cnt + 1'b1;
        if (rd_en && !wr_en) d.cnt = q.cnt - 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) q <= '0;
        else q <= d;
    end

    always_ff @(posedge clk) begin
        if (wr_en) mem[q.wr] <= in_data;
    end
endmodule : cxse_fifo

// [logic/cxse_frame_begin.sv]
// frame begin event for area and line mode acquisition
// assumes first-pixel strobes are one-cycle pulses on accepted pixels
`timescale 1ns/1ps
module cxse_frame_begin (
    input wire logic clk,
    input wire logic rst,
    input wire logic acq_run,
    input wire logic line_mode,
    input wire logic area_first,
    input wire logic line_first,
    input wire logic gen_first,
    output logic begin_evt
);
    typedef struct packed {
        logic evt;
    } cxse_fb_s;
    cxse_fb_s q, d;

    always_comb begin
        d = q;
        d.evt = acq_run && (line_mode ? (gen_first && line_first) : area_first);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) q <= '0;
        else q <= d;
    end

    assign begin_evt = q.evt;

    a_begin_stopped: assert property (@(posedge clk) disable iff (rst)
        !acq_run |=> !begin_evt) else $error("frame begin while stopped");
    a_begin_line: assert property (@(posedge clk) disable iff (rst)
        acq_run && line_mode && gen_first && line_first |=> begin_evt)
        else $error("line frame begin missing");
    a_begin_area: assert property (@(posedge clk) disable iff (rst)
        acq_run && !line_mode && area_first |=> begin_evt)
        else $error("area frame begin missing");
endmodule : cxse_frame_begin

// [logic/cxse_stream_guard.sv]
// stream guard: conforms frames to header size and queues fault events
// assumes a header pulse precedes each frame's pixels; crc pulses come at packet end
`timescale 1ns/1ps
module cxse_stream_guard import cxse_pkg::*; #(
    parameter int PIX_DEPTH = PIX_FIFO_DEPTH,
    parameter int EV_DEPTH = EVQ_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic acq_run,
    input wire logic line_mode,
    input wire logic gen_frame_first,
    input wire logic hdr_valid,
    input wire cxse_hdr_s hdr,
    input wire logic crc_err,
    input wire logic in_valid,
    input wire cxse_pix_s in_pix,
    output logic in_ready,
    output logic out_valid,
    output cxse_pix_s out_pix,
    input wire logic out_ready,
    output logic ev_valid,
    output cxse_evt_s ev_rec,
    input wire logic ev_ready,
    output logic frame_begin_event,
    output logic size_mismatch,
    output logic loss_pending
);
    typedef struct packed {
        cxse_state_e state;
        logic [DIM_W-1:0] col;
        logic [DIM_W-1:0] row;
        logic [DIM_W-1:0] width;
        logic [DIM_W-1:0] height;
        logic [TAG_W-1:0] tag;
        logic [TAG_W-1:0] prev_tag;
        logic [SID_W-1:0] sid;
        logic have_prev;
        logic skip;
        logic fl_mark;
        logic fl_unc;
        logic fl_size;
        logic hold_v;
        logic hold_lossy;
        logic loss_c;
        logic loss_l;
        logic lost_ovf;
        logic [LCNT_W-1:0] lost_cnt;
        cxse_evt_s hold;
    } cxse_guard_s;

    cxse_guard_s q, d;
    logic pin_ready;
    logic push_v;
    cxse_pix_s push_pix;
    logic adv;
    logic beat_last;
    logic line_last;
    logic first_px;
    logic line_first;
    logic size_err;
    logic done;
    logic c_v;
    logic [3:0] c_fl;
    logic l_v;
    logic [TAG_W-1:0] l_tag;
    logic [SID_W-1:0] l_sid;
    logic cand_v;
    cxse_evt_s cand;
    logic [EV_W-1:0] cand_w2;
    logic merge;
    logic evq_ready;
    logic q_push;
    cxse_evt_s q_data;
    logic bump_c;
    logic bump_l;

    function automatic cxse_evt_s mk_evt(input logic [TAG_W-1:0] tag,
        input logic [SID_W-1:0] sid, input logic [3:0] fl, input logic typ);
        cxse_evt_s e;
        e = '0;
        e.w0 = tag;
        e.w1[EV_W-1:SID_LSB] = sid;
        e.w2[W2_SIZE:W2_CRC] = fl;
        e.w3[W3_TYPE] = typ;
        return e;
    endfunction : mk_evt

    always_comb begin
        d = q;
        in_ready = 1'b0;
        push_v = 1'b0;
        push_pix = '0;
        adv = 1'b0;
        first_px = 1'b0;
        line_first = 1'b0;
        size_err = 1'b0;
        done = 1'b0;
        l_v = 1'b0;
        l_tag = q.tag;
        l_sid = q.sid;
        line_last = q.col == q.width - DIM_ONE;
        beat_last = line_last && (q.row == q.height - DIM_ONE);
        case (q.state)
            ST_IDLE: begin
                in_ready = q.skip;
                if (in_valid && q.skip && in_pix.frame_end) d.skip = 1'b0;
                if (hdr_valid) begin
                    if (q.have_prev && hdr.tag != q.prev_tag + TAG_ONE) begin
                        l_v = 1'b1;
                        l_tag = q.prev_tag + TAG_ONE;
                        l_sid = hdr.sid;
                    end
                    d.state = ST_RUN;
                    d.col = '0;
                    d.row = '0;
                    d.width = hdr.width;
                    d.height = hdr.height;
                    d.tag = hdr.tag;
                    d.prev_tag = hdr.tag;
                    d.sid = hdr.sid;
                    d.have_prev = 1'b1;
                    d.fl_mark = hdr.marker_err;
                    d.fl_unc = hdr.uncorr_err;
                    d.fl_size = 1'b0;
                end
            end
            ST_RUN: begin
                in_ready = pin_ready;
                if (in_valid && pin_ready) begin
                    adv = 1'b1;
                    push_pix.data = in_pix.data;
                    first_px = (q.col == '0) && (q.row == '0);
                    line_first = q.col == '0;
                    if (beat_last) begin
                        if (in_pix.frame_end) begin
                            done = 1'b1;
                        end else begin
                            size_err = 1'b1;
                            d.state = ST_DRAIN;
                        end
                    end else if (in_pix.frame_end) begin
                        size_err = 1'b1;
                        d.state = ST_PAD;
                    end
                end
            end
            ST_PAD: begin
                in_ready = q.skip;
                if (in_valid && q.skip && in_pix.frame_end) d.skip = 1'b0;
                if (pin_ready) begin
                    adv = 1'b1;
                    push_pix.data = FILL_PIX;
                    done = beat_last;
                end
            end
            ST_DRAIN: begin
                in_ready = 1'b1;
                done = in_valid && in_pix.frame_end;
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase
        if (adv) begin
            push_v = 1'b1;
            push_pix.line_end = line_last;
            push_pix.frame_end = beat_last;
            if (line_last) begin
                d.col = '0;
                d.row = q.row + DIM_ONE;
            end else begin
                d.col = q.col + DIM_ONE;
            end
        end
        if (hdr_valid && q.state != ST_IDLE) begin
            l_v = 1'b1;
            l_tag = hdr.tag;
            l_sid = hdr.sid;
            d.prev_tag = hdr.tag;
            d.skip = 1'b1;
        end
        if (size_err) d.fl_size = 1'b1;
        if (done) d.state = ST_IDLE;

        c_fl = {done && q.fl_size, done && q.fl_unc, done && q.fl_mark, crc_err};
        c_v = c_fl != '0;
        cand_v = c_v || l_v;
        if (c_v) cand = mk_evt(q.tag, q.sid, c_fl, TYPE_CORRUPT);
        else cand = mk_evt(l_tag, l_sid, 4'h0, TYPE_LOST);
        cand_w2 = cand.w2;
        merge = cand_v && q.hold_v && !q.hold_lossy && (q.hold.w0 == cand.w0)
            && (q.hold.w1 == cand.w1) && (q.hold.w3[W3_TYPE] == cand.w3[W3_TYPE]);

        q_push = 1'b0;
        q_data = q.hold;
        bump_c = 1'b0;
        bump_l = c_v && l_v;
        if (merge) begin
            d.hold.w2 = q.hold.w2 | cand.w2;
        end else if (cand_v && q.hold_v && !evq_ready) begin
            if (c_v) bump_c = 1'b1;
            else bump_l = 1'b1;
        end else if (cand_v) begin
            q_push = q.hold_v;
            d.hold = cand;
            d.hold.w3[W3_LOSS_C] = q.loss_c;
            d.hold.w3[W3_LOSS_L] = q.loss_l;
            d.hold.w3[EV_W-1:W3_CNT_LSB] = q.lost_ovf ? '0 : q.lost_cnt;
            d.hold_v = 1'b1;
            d.hold_lossy = q.loss_c || q.loss_l;
            d.loss_c = 1'b0;
            d.loss_l = 1'b0;
            d.lost_cnt = '0;
            d.lost_ovf = 1'b0;
        end else if (q.hold_v && q.state == ST_IDLE && evq_ready) begin
            q_push = 1'b1;
            d.hold_v = 1'b0;
            d.hold_lossy = 1'b0;
        end
        if (bump_c) d.loss_c = 1'b1;
        if (bump_l) begin
            d.loss_l = 1'b1;
            if (d.lost_ovf || d.lost_cnt == LCNT_MAX) begin
                d.lost_cnt = '0;
                d.lost_ovf = 1'b1;
            end else begin
                d.lost_cnt = d.lost_cnt + LCNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) q <= '0;
        else q <= d;
    end

    cxse_fifo #(.W($bits(cxse_pix_s)), .DEPTH(PIX_DEPTH)) u_pix_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_v),
        .in_data(push_pix),
        .in_ready(pin_ready),
        .out_valid(out_valid),
        .out_data(out_pix),
        .out_ready(out_ready)
    );

    cxse_fifo #(.W($bits(cxse_evt_s)), .DEPTH(EV_DEPTH)) u_evt_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(q_push),
        .in_data(q_data),
        .in_ready(evq_ready),
        .out_valid(ev_valid),
        .out_data(ev_rec),
        .out_ready(ev_ready)
    );

    cxse_frame_begin u_begin (
        .clk(clk),
        .rst(rst),
        .acq_run(acq_run),
        .line_mode(line_mode),
        .area_first(first_px),
        .line_first(line_first),
        .gen_first(gen_frame_first),
        .begin_evt(frame_begin_event)
    );

    assign size_mismatch = q.fl_size;
    assign loss_pending = q.loss_c || q.loss_l;

    a_drain_silent: assert property (@(posedge clk) disable iff (rst)
        q.state == ST_DRAIN |-> !push_v) else $error("surplus pixel forwarded");
    a_pad_filler: assert property (@(posedge clk) disable iff (rst)
        q.state == ST_PAD && pin_ready |-> push_v && push_pix.data == FILL_PIX)
        else $error("pad cycle without filler");
    a_short_size: assert property (@(posedge clk) disable iff (rst)
        q.state == ST_RUN && in_valid && pin_ready && in_pix.frame_end && !beat_last
        |=> q.fl_size && q.state == ST_PAD) else $error("short frame not flagged");
    a_gap_lost: assert property (@(posedge clk) disable iff (rst)
        q.state == ST_IDLE && hdr_valid && q.have_prev && hdr.tag != q.prev_tag + TAG_ONE
        |-> l_v && l_tag == q.prev_tag + TAG_ONE) else $error("tag gap not reported");
    a_busy_drop: assert property (@(posedge clk) disable iff (rst)
        q.state == ST_PAD && hdr_valid |=> q.skip) else $error("frame during pad kept");
    a_corrupt_loss: assert property (@(posedge clk) disable iff (rst)
        c_v && q.hold_v && !evq_ready && !merge |=> q.loss_c)
        else $error("corrupt loss not recorded");
    a_lost_count: assert property (@(posedge clk) disable iff (rst)
        bump_l && q.hold_v && !evq_ready && !merge && !q.lost_ovf && q.lost_cnt != LCNT_MAX
        |=> q.lost_cnt == $past(q.lost_cnt) + LCNT_ONE) else $error("lost count wrong");
    a_lossy_apart: assert property (@(posedge clk) disable iff (rst)
        q.hold_v && q.hold_lossy && cand_v && evq_ready |=> q.hold.w2 == $past(cand_w2))
        else $error("lossy event merged");
    a_type_lost: assert property (@(posedge clk) disable iff (rst)
        l_v && !c_v && !q.hold_v |=> q.hold_v && q.hold.w3[W3_TYPE] == TYPE_LOST)
        else $error("lost event type wrong");
endmodule : cxse_stream_guard

// [pkg/cxse_pkg.sv]
// constants, field layouts and carrier types of the stream fault event block
// assumes one acquisition clock; header and crc reports arrive as one-cycle pulses
// Behaviour
// - frames longer than the header size lose their surplus pixels and lines.
// - frames shorter than the header size are padded with filler to full size.
// - any header versus received size mismatch also raises a fault event.
// - each fault event is a record of four sixteen-bit words.
// - word zero carries the image tag of the affected frame.
// - word one carries the stream id in its upper byte, lower byte reserved.
// - word two flags crc, marker, uncorrectable header and size errors in bits 0-3.
// - word three bit zero: 0 frame already forwarded, 1 frame discarded.
// - a gap in incoming frame tags raises a discarded-frame event.
// - a frame dropped while padding raises a discarded-frame event.
// - a dropped corrupted-frame event sets word three bit one later.
// - dropped discarded-frame events set bit two and count in bits 3-15.
// - every delivered event notifies software; same-tag events may merge, flags ORed.
// - an event carrying loss information is never merged with later ones.
// - crc events are reported late and may name a neighbouring frame tag.
// - one event path serves both taps, told apart by stream id.
// - area mode raises a frame begin event on each frame's first pixel.
// - frame begin events are suppressed while acquisition is stopped.
// - line mode frame begin coincides with generated frame's first pixel.
package cxse_pkg;
    localparam int PIX_W = 16;
    localparam int DIM_W = 17;
    localparam int EV_W = 16;
    localparam int TAG_W = 16;
    localparam int SID_W = 8;
    localparam int SID_LSB = 8;
    localparam int LCNT_W = 13;
    localparam int W2_CRC = 0;
    localparam int W2_SIZE = 3;
    localparam int W3_TYPE = 0;
    localparam int W3_LOSS_C = 1;
    localparam int W3_LOSS_L = 2;
    localparam int W3_CNT_LSB = 3;
    localparam int PIX_FIFO_DEPTH = 8;
    localparam int EVQ_DEPTH = 8;
    localparam logic TYPE_CORRUPT = 1'h0;
    localparam logic TYPE_LOST = 1'h1;
    localparam logic [PIX_W-1:0] FILL_PIX = 16'h0000;
    localparam logic [DIM_W-1:0] DIM_ONE = 17'h00001;
    localparam logic [TAG_W-1:0] TAG_ONE = 16'h0001;
    localparam logic [LCNT_W-1:0] LCNT_ONE = 13'h0001;
    localparam logic [LCNT_W-1:0] LCNT_MAX = 13'h1FFF;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAD, ST_DRAIN} cxse_state_e;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [SID_W-1:0] sid;
        logic [DIM_W-1:0] width;
        logic [DIM_W-1:0] height;
        logic marker_err;
        logic uncorr_err;
    } cxse_hdr_s;

    typedef struct packed {
        logic [PIX_W-1:0] data;
        logic line_end;
        logic frame_end;
    } cxse_pix_s;

    typedef struct packed {
        logic [EV_W-1:0] w3;
        logic [EV_W-1:0] w2;
        logic [EV_W-1:0] w1;
        logic [EV_W-1:0] w0;
    } cxse_evt_s;
endpackage : cxse_pkg
